// >>> design/rirc_bus_if.sv
// register link between the calibration host and the readout device
// one clock; host is master, device answers reads one cycle later
`default_nettype none
interface rirc_bus_if;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  modport dev  (input addr, input wdata, input wr, input rd, output rdata);
  modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface : rirc_bus_if
`default_nettype wire

// >>> design/rirc_dev.sv
// readout device: averaged log strength, trim and gain registers
// assumes channel filter amplitudes arrive as one-cycle valid pulses
`default_nettype none
module rirc_dev #(
  parameter int AW = rirc_pkg::AMP_W
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          ce,
  rirc_bus_if.dev            bus,
  input  wire logic          samp_valid,
  input  wire logic [AW-1:0] samp_amp,
  output logic [7:0]         phase_trim,
  output logic [7:0]         gain_trim,
  output logic [4:0]         gain_config_three,
  output logic [1:0]         level_average_select,
  output logic [6:0]         strength
);
  import rirc_pkg::*;

  logic [AW+3:0] acc_q;
  logic [3:0]    cnt_q;
  logic [6:0]    strength_q;
  logic [1:0]    avg_q;
  logic [4:0]    gain_q;
  logic [7:0]    ptrim_q;
  logic [7:0]    gtrim_q;
  logic [7:0]    rdata_q;
  logic [AW+3:0] sum_d;
  logic [AW+3:0] avg_d;

  // 4*log2 with two fraction bits below the leading one
  function automatic logic [6:0] log4(input logic [AW+3:0] x);
    int            p;
    logic [AW+5:0] t;
    int            v;
    p = 0;
    for (int i = 0; i < AW + 4; i++)
      if (x[i]) p = i;
    t = {x, 2'b00} >> p;
    v = 4 * p + int'(t[1:0]);
    if (x == '0) v = 0;
    if (v > int'(STRENGTH_MAX)) v = int'(STRENGTH_MAX);
    return 7'(v);
  endfunction : log4

  assign sum_d = acc_q + (AW+4)'(samp_amp);
  // shift widened so that select 3 shifts by four, not zero
  assign avg_d = sum_d >> (3'(avg_q) + 3'h1);

  // average 2^(sel+1) samples, publish on the last one
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      acc_q      <= '0;
      cnt_q      <= '0;
      strength_q <= '0;
    end
    else if (ce && samp_valid)
    begin
      if (cnt_q == 4'((2 << avg_q) - 1)) // RQ4 RQ5
      begin
        acc_q      <= '0;
        cnt_q      <= '0;
        strength_q <= log4(avg_d); // RQ1 RQ2 RQ3 RQ16
      end
      else
      begin
        acc_q <= sum_d;
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end

  // writable registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      avg_q   <= AVG_RST;
      gain_q  <= GAIN_RST;
      ptrim_q <= 8'h00;
      gtrim_q <= 8'h00;
    end
    else if (ce && bus.wr)
    begin
      unique case (bus.addr)
        DEV_CONFIG:
        begin
          avg_q  <= bus.wdata[CFG_AVG_LSB +: 2];
          gain_q <= bus.wdata[CFG_GAIN_LSB +: 5]; // RQ7
        end
        DEV_PHASE: ptrim_q <= bus.wdata; // RQ8
        DEV_GAIN:  gtrim_q <= bus.wdata; // RQ8
        default: ;
      endcase
    end
  end

  // read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk)
  begin
    if (rst)
      rdata_q <= 8'h00;
    else if (ce && bus.rd)
    begin
      unique case (bus.addr)
        DEV_STRENGTH: rdata_q <= {1'b0, strength_q}; // RQ1
        DEV_CONFIG:   rdata_q <= {1'b0, gain_q, avg_q};
        DEV_PHASE:    rdata_q <= ptrim_q;
        DEV_GAIN:     rdata_q <= gtrim_q;
        default:      rdata_q <= 8'h00;
      endcase
    end
  end

  assign bus.rdata            = rdata_q;
  assign phase_trim           = ptrim_q;
  assign gain_trim            = gtrim_q;
  assign gain_config_three    = gain_q;
  assign level_average_select = avg_q;
  assign strength             = strength_q;
endmodule : rirc_dev
`default_nettype wire

// >>> design/rirc_host.sv
// calibration host: sweeps phase and gain trims, minimises strength
// assumes the device answers reads one cycle after the strobe
// Function
// (RQ1) strength is 7 bits, zero to 106
// (RQ2) strength is four times log2 amplitude
// (RQ3) one strength step is 1.5 dB
// (RQ4) averaging field sets samples and refresh rate
// (RQ5) field 11 averages sixteen samples
// (RQ6) power is 1.5*reading minus 3*gain minus offset
// (RQ7) gain field steps roughly 3 dB
// (RQ8) trim registers correct I/Q phase and gain
// (RQ9) start at zero estimates, step 64, halve later
// (RQ10) five trim points from +2 to -2 steps
// (RQ11) settle 3 ms, average 8 reads 0.5 ms apart
// (RQ12) use averaging 11 during calibration
// (RQ13) curvature, rounded clamped correction, add to estimate
// (RQ14) repeat while step above one, write finals
// (RQ15) reads per measurement may grow each pass
// (RQ16) strength stays stable between refreshes
`default_nettype none
module rirc_host #(
  parameter int SETTLE_CYCLES = rirc_pkg::SETTLE_CYC,
  parameter int GAP_CYCLES    = rirc_pkg::READ_GAP_CYC
) (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          ce,
  rirc_bus_if.host                           bus,
  input  wire logic [rirc_pkg::HADDR_W-1:0]  reg_addr,
  input  wire logic [rirc_pkg::HDATA_W-1:0]  reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic [rirc_pkg::HDATA_W-1:0]       reg_rdata
);
  import rirc_pkg::*;

  typedef enum {S_IDLE, S_CFG, S_OTHER, S_POINT, S_SETTLE, S_RD, S_RDW,
                S_RDCAP, S_GAP, S_CALC, S_FIN_P, S_FIN_G} rirc_hst_e;

  rirc_hst_e          st_q;
  logic               sweep_q;
  logic [2:0]         idx_q;
  logic [7:0]         step_q;
  logic signed [7:0]  xp_q;
  logic signed [7:0]  xg_q;
  logic [6:0]         y_q [5];
  logic [12:0]        acc_q;
  logic [6:0]         rcnt_q;
  logic [31:0]        tmr_q;
  logic [6:0]         meas_q;
  logic [3:0]         pass_q;
  logic               busy_q;
  logic               done_q;
  logic [2:0]         nlog_q;
  logic               grow_q;
  logic [4:0]         maxg_q;
  logic [7:0]         offs_q;
  logic [3:0]         baddr_q;
  logic [7:0]         bdata_q;
  logic               bwr_q;
  logic               brd_q;
  logic [15:0]        rdata_q;
  logic               start;
  logic [12:0]        sum_d;
  logic [6:0]         avg_d;
  logic signed [15:0] power_d;

  // estimate plus offset, capped to the trim range
  function automatic logic signed [7:0] sat8(input int v);
    if (v > TRIM_MAX) v = TRIM_MAX;
    if (v < TRIM_MIN) v = TRIM_MIN;
    return 8'(v);
  endfunction : sat8

  // rounded, clamped correction from five measurements
  function automatic int corr(input logic [6:0] y [5], input int dx);
    int a;
    int n;
    int d;
    int q;
    a = 2 * (int'(y[0]) - int'(y[2]) + int'(y[4])) - (int'(y[1]) + int'(y[3]));
    n = 7 * dx * (2 * (int'(y[0]) - int'(y[4])) + int'(y[1]) - int'(y[3]));
    if (a > 0)
    begin
      d = 10 * a;
      q = ((n < 0 ? -n : n) * 2 + d) / (2 * d);
      if (n < 0) q = -q;
    end
    else if (int'(y[0]) + int'(y[1]) > int'(y[3]) + int'(y[4]))
      q = dx;
    else
      q = -dx;
    if (q > dx) q = dx;
    if (q < -dx) q = -dx;
    return q;
  endfunction : corr

  assign start   = reg_wr && (reg_addr == H_CTRL) && reg_wdata[CTRL_START] && !busy_q;
  assign sum_d   = acc_q + 13'(bus.rdata[6:0]);
  assign avg_d   = 7'(sum_d >> nlog_q);
  // half-dB units: 3*reading - 6*gain - offset
  assign power_d = 16'(3 * int'(meas_q) - 6 * int'(maxg_q) - int'(offs_q)); // RQ6

  // calibration sequencer
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_q    <= S_IDLE;
      sweep_q <= 1'b0;
      idx_q   <= 3'h0;
      step_q  <= STEP_START;
      xp_q    <= 8'sh00;
      xg_q    <= 8'sh00;
      y_q     <= '{default: 7'h00};
      acc_q   <= '0;
      rcnt_q  <= '0;
      tmr_q   <= '0;
      meas_q  <= '0;
      pass_q  <= '0;
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
      baddr_q <= 4'h0;
      bdata_q <= 8'h00;
      bwr_q   <= 1'b0;
      brd_q   <= 1'b0;
    end
    else if (ce)
    begin
      bwr_q <= 1'b0;
      brd_q <= 1'b0;
      unique case (st_q)
        S_IDLE:
          if (start)
          begin
            busy_q <= 1'b1;
            done_q <= 1'b0;
            st_q   <= S_CFG;
          end
        S_CFG:
        begin
          bwr_q   <= 1'b1;
          baddr_q <= DEV_CONFIG;
          bdata_q <= {1'b0, maxg_q, AVG_CAL}; // RQ12
          xp_q    <= 8'sh00; // RQ9
          xg_q    <= 8'sh00;
          step_q  <= STEP_START;
          sweep_q <= 1'b0;
          pass_q  <= '0;
          st_q    <= S_OTHER;
        end
        S_OTHER:
        begin
          bwr_q   <= 1'b1; // RQ10
          baddr_q <= sweep_q ? DEV_PHASE : DEV_GAIN;
          bdata_q <= sweep_q ? xp_q : xg_q;
          idx_q   <= 3'h4;
          st_q    <= S_POINT;
        end
        S_POINT:
        begin
          bwr_q   <= 1'b1;
          baddr_q <= sweep_q ? DEV_GAIN : DEV_PHASE;
          bdata_q <= sat8(int'(sweep_q ? xg_q : xp_q)
                     + (int'(idx_q) - 2) * int'(step_q)); // RQ10
          tmr_q   <= 32'(SETTLE_CYCLES - 1); // RQ11
          acc_q   <= '0;
          rcnt_q  <= '0;
          st_q    <= S_SETTLE;
        end
        S_SETTLE, S_GAP:
          if (tmr_q == '0)
            st_q <= S_RD;
          else
            tmr_q <= tmr_q - 32'h1;
        S_RD:
        begin
          brd_q   <= 1'b1;
          baddr_q <= DEV_STRENGTH;
          st_q    <= S_RDW;
        end
        S_RDW: st_q <= S_RDCAP;
        S_RDCAP:
        begin
          acc_q <= sum_d;
          if (rcnt_q == 7'((1 << nlog_q) - 1)) // RQ11 RQ15
          begin
            y_q[idx_q] <= avg_d;
            meas_q     <= avg_d;
            if (idx_q == 3'h0)
              st_q <= S_CALC;
            else
            begin
              idx_q <= idx_q - 3'h1;
              st_q  <= S_POINT;
            end
          end
          else
          begin
            rcnt_q <= rcnt_q + 7'h1;
            tmr_q  <= 32'(GAP_CYCLES - 4); // RQ11
            st_q   <= S_GAP;
          end
        end
        S_CALC:
        begin
          if (sweep_q)
            xg_q <= sat8(int'(xg_q) + corr(y_q, int'(step_q))); // RQ13
          else
            xp_q <= sat8(int'(xp_q) + corr(y_q, int'(step_q))); // RQ13
          if (!sweep_q)
          begin
            sweep_q <= 1'b1;
            st_q    <= S_OTHER;
          end
          else if (step_q > 8'h01) // RQ14
          begin
            step_q  <= step_q >> 1; // RQ9
            sweep_q <= 1'b0;
            pass_q  <= pass_q + 4'h1;
            st_q    <= S_OTHER;
          end
          else
            st_q <= S_FIN_P;
        end
        S_FIN_P:
        begin
          bwr_q   <= 1'b1; // RQ14
          baddr_q <= DEV_PHASE;
          bdata_q <= xp_q;
          st_q    <= S_FIN_G;
        end
        S_FIN_G:
        begin
          bwr_q   <= 1'b1;
          baddr_q <= DEV_GAIN;
          bdata_q <= xg_q;
          busy_q  <= 1'b0;
          done_q  <= 1'b1;
          st_q    <= S_IDLE;
        end
      endcase
    end
  end

  // reads per measurement, optionally doubled each pass
  always_ff @(posedge clk)
  begin
    if (rst)
      nlog_q <= NLOG_RST;
    else if (ce)
    begin
      if (start)
        nlog_q <= reg_wdata[CTRL_NLOG_LSB +: 3];
      else if (st_q == S_CALC && sweep_q && step_q > 8'h01 && grow_q
               && nlog_q < NLOG_MAX)
        nlog_q <= nlog_q + 3'h1; // RQ15
    end
  end

  // host configuration registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      grow_q <= 1'b0;
      maxg_q <= GAIN_RST;
      offs_q <= 8'h00;
    end
    else if (ce && reg_wr)
    begin
      if (reg_addr == H_CTRL && !busy_q)
      begin
        grow_q <= reg_wdata[CTRL_GROW];
        maxg_q <= reg_wdata[CTRL_GAIN_LSB +: 5];
      end
      if (reg_addr == H_OFFSET)
        offs_q <= reg_wdata[7:0];
    end
  end

  // user read port, data one cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (rst)
      rdata_q <= 16'h0000;
    else if (ce && reg_rd)
    begin
      unique case (reg_addr)
        H_CTRL:   rdata_q <= {3'h0, maxg_q, 1'b0, nlog_q, 2'h0, grow_q, 1'b0};
        H_STATUS: rdata_q <= {step_q, pass_q, 2'h0, done_q, busy_q};
        H_RESULT: rdata_q <= {xg_q, xp_q};
        H_POWER:  rdata_q <= power_d;
        H_OFFSET: rdata_q <= {8'h00, offs_q};
        default:  rdata_q <= 16'h0000;
      endcase
    end
  end

  assign bus.addr  = baddr_q;
  assign bus.wdata = bdata_q;
  assign bus.wr    = bwr_q;
  assign bus.rd    = brd_q;
  assign reg_rdata = rdata_q;
endmodule : rirc_host
`default_nettype wire

// >>> design/rirc_pkg.sv
// constants shared by the strength readout device and its calibration host
// assumes one 50 MHz clock feeding both ends
`default_nettype none
package rirc_pkg;
  localparam int CLK_HZ        = 50_000_000;
  localparam int SETTLE_US     = 3000;
  localparam int READ_GAP_US   = 500;
  localparam int SETTLE_CYC    = (SETTLE_US * (CLK_HZ / 1_000_000));
  localparam int READ_GAP_CYC  = (READ_GAP_US * (CLK_HZ / 1_000_000));
  localparam int AMP_W         = 16;
  localparam int ADDR_W        = 4;
  localparam int DATA_W        = 8;
  localparam int HADDR_W       = 5;
  localparam int HDATA_W       = 16;
  // device register map
  localparam logic [3:0] DEV_STRENGTH = 4'h0;
  localparam logic [3:0] DEV_CONFIG   = 4'h1;
  localparam logic [3:0] DEV_PHASE    = 4'h2;
  localparam logic [3:0] DEV_GAIN     = 4'h3;
  localparam int CFG_AVG_LSB   = 0;
  localparam int CFG_GAIN_LSB  = 2;
  localparam logic [1:0] AVG_RST   = 2'h0;
  localparam logic [1:0] AVG_CAL   = 2'h3;
  localparam logic [4:0] GAIN_RST  = 5'h00;
  localparam logic [6:0] STRENGTH_MAX = 7'h6A;
  // host register map
  localparam logic [4:0] H_CTRL    = 5'h00;
  localparam logic [4:0] H_STATUS  = 5'h04;
  localparam logic [4:0] H_RESULT  = 5'h08;
  localparam logic [4:0] H_POWER   = 5'h0C;
  localparam logic [4:0] H_OFFSET  = 5'h10;
  localparam int CTRL_START    = 0;
  localparam int CTRL_GROW     = 1;
  localparam int CTRL_NLOG_LSB = 4;
  localparam int CTRL_GAIN_LSB = 8;
  localparam logic [2:0] NLOG_RST  = 3'h3;
  localparam logic [2:0] NLOG_MAX  = 3'h6;
  localparam logic [7:0] STEP_START = 8'h40;
  localparam int TRIM_MAX      = 127;
  localparam int TRIM_MIN      = -128;
endpackage : rirc_pkg
`default_nettype wire

// >>> dv/rirc_monitor.sv
// bus checker for the link between the calibration host and the readout device
// assumes one clock and a synchronous active-high reset shared by both ends
`default_nettype none
module rirc_monitor (
  input wire logic                         clk,
  input wire logic                         rst,
  input wire logic [rirc_pkg::ADDR_W-1:0]  addr,
  input wire logic [rirc_pkg::DATA_W-1:0]  wdata,
  input wire logic                         wr,
  input wire logic                         rd,
  input wire logic [rirc_pkg::DATA_W-1:0]  rdata
);
  import rirc_pkg::*;

  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);

  a_no_dual_strobe: assert property (!(wr && rd))
    else $error("write and read strobes in one cycle");
  a_strength_range: assert property (
    rd && addr == DEV_STRENGTH |=> rdata <= {1'b0, STRENGTH_MAX})
    else $error("strength read above range");
  a_rdata_holds: assert property (!rd |=> $stable(rdata))
    else $error("read data changed without a read");
  a_settle_gap: assert property (
    wr && (addr == DEV_PHASE || addr == DEV_GAIN) |=> !rd [*8])
    else $error("read too soon after trim write");
  a_read_spacing: assert property (rd |=> !rd [*3])
    else $error("strength reads too close");
  a_cal_average: assert property (wr && addr == DEV_CONFIG |-> wdata[1:0] == AVG_CAL)
    else $error("calibration config without full averaging");
  a_config_pad: assert property (wr && addr == DEV_CONFIG |-> wdata[7] == 1'b0)
    else $error("config write sets unused bit");
  a_read_strength: assert property (rd |-> addr == DEV_STRENGTH)
    else $error("host read of a register other than strength");

  c_strength_read: cover property (rd && addr == DEV_STRENGTH);
  c_phase_write: cover property (wr && addr == DEV_PHASE);
  c_gain_write: cover property (wr && addr == DEV_GAIN);
endmodule : rirc_monitor
`default_nettype wire

// >>> dv/test_rssi_image_rejection_cal.sv
// self-checking bench: host and device joined by the register link
// assumes short settle and read-gap counts so the sweep fits a short run
`default_nettype none
module test_rssi_image_rejection_cal;
  timeunit 1ns;
  timeprecision 1ps;
  import rirc_pkg::*;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic        samp_valid = 1'b0;
  logic [31:0] samp_amp = 32'h0;
  logic [4:0]  reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic [7:0]  phase_trim;
  logic [7:0]  gain_trim;
  logic [4:0]  gcfg;
  logic [1:0]  avg_sel;
  logic [6:0]  strength;
  int          seed = 26991;
  int          miscompares = 0;
  int          checks_done = 0;
  int          cyc = 0;

  rirc_bus_if bus ();
  rirc_dev #(.AW(32)) i_rirc_dev (.clk(clk), .rst(rst), .ce(ce), .bus(bus),
    .samp_valid(samp_valid), .samp_amp(samp_amp), .phase_trim(phase_trim),
    .gain_trim(gain_trim), .gain_config_three(gcfg), .level_average_select(avg_sel),
    .strength(strength));
  rirc_host #(.SETTLE_CYCLES(20), .GAP_CYCLES(8)) i_rirc_host (.clk(clk), .rst(rst),
    .ce(ce), .bus(bus), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  rirc_monitor i_rirc_monitor (.clk(clk), .rst(rst), .addr(bus.addr), .wdata(bus.wdata),
    .wr(bus.wr), .rd(bus.rd), .rdata(bus.rdata));

  always #10 clk = ~clk;

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      miscompares++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk

  task automatic hwr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : hwr

  task automatic hrd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : hrd

  // one filter sample; c low means the sample must be ignored
  task automatic push(input logic [31:0] amp, input logic c);
    @(posedge clk);
    ce <= c;
    samp_valid <= 1'b1;
    samp_amp <= amp;
    @(posedge clk);
    ce <= 1'b1;
    samp_valid <= 1'b0;
    #1;
  endtask : push

  function automatic logic [6:0] exp_str(input logic [32:0] v);
    int m;
    int s;
    m = -1;
    for (int i = 0; i < 33; i++)
      if (v[i])
        m = i;
    if (m < 0)
      return 7'h00;
    s = 4 * m + int'((v >> (m - 2)) & 33'h3);
    if (s > int'(STRENGTH_MAX))
      s = int'(STRENGTH_MAX);
    return 7'(s);
  endfunction : exp_str

  initial
  begin
    logic [31:0] a;
    logic [31:0] b;
    logic [15:0] d;
    logic [4:0]  g;
    logic [2:0]  n;
    logic [7:0]  off;
    int          p;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    hrd(H_CTRL, d);
    chk(32'(d), 32'h0030);
    hrd(H_STATUS, d);
    chk(32'(d), 32'h4000);
    chk({gcfg, avg_sel, phase_trim, gain_trim}, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 24; i++)
    begin
      a = (32'($random(seed)) >> ($unsigned($random(seed)) % 29)) | 32'h4;
      b = (32'($random(seed)) >> ($unsigned($random(seed)) % 29)) | 32'h4;
      if (i < 2)
      begin
        a = (i == 0) ? 32'h0 : 32'hFFFF_FFFF;
        b = a;
      end
      d = {9'h0, strength};
      push(a, 1'b1);
      chk(32'(strength), 32'(d));
      push(32'h4, 1'b0);
      push(b, 1'b1);
      chk(32'(strength), 32'(exp_str((33'(a) + 33'(b)) >> 1)));
    end
    $display("test strength done");
    g = 5'($random(seed));
    n = 3'(1 + $unsigned($random(seed)) % 3);
    off = 8'($random(seed));
    a = (32'($random(seed)) >> ($unsigned($random(seed)) % 29)) | 32'h4;
    samp_valid <= 1'b1;
    samp_amp <= a;
    hwr(H_OFFSET, {8'h00, off});
    hwr(5'h14, 16'hFFFF);
    hwr(H_CTRL, {3'h0, g, 1'b0, n, 4'h1});
    repeat (40) @(posedge clk);
    chk(32'(avg_sel), 32'(AVG_CAL));
    chk(32'(gcfg), 32'(g));
    hwr(H_CTRL, {3'h0, ~g, 8'h01});
    for (int i = 0; i < 20000; i++)
    begin
      hrd(H_STATUS, d);
      if (d[1])
        break;
    end
    chk(32'(d & 16'hFF03), 32'h0102);
    hrd(H_RESULT, d);
    chk(32'(d), 32'h8181);
    chk({16'h0, gain_trim, phase_trim}, 32'h8181);
    chk(32'(strength), 32'(exp_str(33'(a))));
    p = 3 * int'(exp_str(33'(a))) - 6 * int'(g) - int'(off);
    hrd(H_POWER, d);
    chk(32'(d), 32'(16'(p)));
    hrd(H_OFFSET, d);
    chk(32'(d[7:0]), 32'(off));
    $display("test calibration done");
    results();
  end
endmodule : test_rssi_image_rejection_cal
`default_nettype wire
